// file: eeprom_boot_defs.vh
/*
 * constants for the non-volatile map and boot configuration loader:
 * memory sections, page-0 configuration bytes, bus register offsets.
 * assumes inclusion by the loader, its assertion module and the bench; definitions only.
 */
// Contract
// - 8 kB storage in 64-byte pages
// - program one page per operation
// - page 0: low half read-only, high half rw
// - reset image and user area read/write
// - key area write-only, preset area read-only
// - version byte tracks initialisation data revision
// - hardware revision hardwired at register 7Fh
// - pin address is 10101 plus two pins
// - interface bit 4 selects address source
// - interface bit 7 selects speed variant
// - interface bit 3 disables boundary scan
// - interface bits 2:0 choose host link
// - secure module address always from stored byte
// - preset entry: 16 tx, 8 rx bytes
// - transmit check seed from stored preset; the code loads it from page-0 bytes 26h-27h at boot instead
// - copy reset image to registers at start-up
// - load command copies preset to tx/rx registers
`ifndef EEPROM_BOOT_DEFS_VH
`define EEPROM_BOOT_DEFS_VH

// ----------------------------------------------------------------
// memory map
// ----------------------------------------------------------------
`define EE_BYTES 8192
`define EE_AW 13
`define PAGE_BYTES 64
`define INFO_LAST 13'h001F
`define IMG_FIRST 13'h0040
`define IMG_BYTES 128
`define KEY_FIRST 13'h1800
`define KEY_LAST 13'h1BFF
`define PRESET_FIRST 13'h1C00
`define PRESET_TX_BYTES 16
`define PRESET_RX_BYTES 8
`define PRESET_ENTRY 24
`define PRESET_ENTRIES 42

// ----------------------------------------------------------------
// page-0 bytes
// ----------------------------------------------------------------
`define PRODUCT_ADDR 13'h0001
`define VERSION_ADDR 13'h0003
`define CFG_SLAVE_ADDR 13'h0020
`define CFG_IFACE 13'h0021
`define CFG_SAM_ADDR 13'h0022
`define CFG_PROT_RX 13'h0023
`define CFG_PROT_TX 13'h0024
`define CFG_TX_SEED 13'h0026
`define CFG_RX_SEED 13'h0028
`define IFACE_RST 8'h80
`define IFACE_SPEED_BIT 7
`define IFACE_ADDRSRC_BIT 4
`define IFACE_BSCAN_BIT 3
`define IFACE_PINSEL_BIT 2
`define PIN_ADDR_PREFIX 5'h15

// ----------------------------------------------------------------
// bus registers (byte addresses)
// ----------------------------------------------------------------
`define REG_PTR 12'h000
`define REG_DATA 12'h004
`define REG_CMD 12'h008
`define REG_STATUS 12'h00C
`define REG_CONFIG 12'h010
`define REG_HWREV 12'h1FC
`define CMD_PROG_BIT 0
`define CMD_RELOAD_BIT 1
`define CMD_LOAD_BIT 2
`define STAT_BUSY_BIT 0
`define STAT_ERR_BIT 1
`define STAT_DONE_BIT 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: eeprom_boot_loader.v
/*
 * non-volatile memory map with section access rights, page programming,
 * start-up copy of the register reset image, preset loading and decode
 * of the page-0 configuration bytes; software reaches it over AXI4-Lite.
 * assumes one clock, synchronous pin inputs, and a register bank that
 * accepts one byte per cycle on the cfg write port.
 */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "eeprom_boot_defs.vh"

module eeprom_boot_loader #(
	parameter [7:0] PRODUCT_CODE = 8'h5A, // arbitrary value
	parameter [7:0] INIT_VERSION = 8'h01, // arbitrary value
	parameter [7:0] HW_REVISION = 8'h3C, // arbitrary value
	parameter [7:0] TX_REG_BASE = 8'h28,
	parameter [7:0] RX_REG_BASE = 8'h38
) (
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_ce,
	input wire [11:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output wire o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output wire o_s_axi_wready,
	output wire [1:0] o_s_axi_bresp,
	output wire o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [11:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output wire o_s_axi_arready,
	output wire [31:0] o_s_axi_rdata,
	output wire [1:0] o_s_axi_rresp,
	output wire o_s_axi_rvalid,
	input wire i_s_axi_rready,
	input wire i_iface_select_pin_a,
	input wire i_iface_select_pin_c,
	input wire [1:0] i_host_strap,
	output reg [1:0] o_host_sel,
	output reg [6:0] o_slave_addr,
	output reg o_fast_plus_speed_select,
	output reg o_bscan_en,
	output reg [6:0] o_secure_module_slave_addr,
	output reg [7:0] o_boot_receive_protocol,
	output reg [7:0] o_boot_transmit_protocol,
	output reg [15:0] o_transmit_check_seed,
	output reg [15:0] o_receive_check_seed,
	output wire [7:0] o_hw_revision,
	output wire o_boot_done,
	output reg o_cfg_we,
	output reg [7:0] o_cfg_addr,
	output reg [7:0] o_cfg_data
);

	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_BOOT = 2'd1;
	localparam [1:0] ST_PROG = 2'd2;
	localparam [1:0] ST_LOAD = 2'd3;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	reg [7:0] mem [0:`EE_BYTES-1];
	reg [7:0] page_buf [0:`PAGE_BYTES-1];
	integer k;

	// factory content standing in for the programmed cells
	initial begin
		for (k = 0; k < `EE_BYTES; k = k + 1) begin
			mem[k] = 8'h00;
		end
		mem[`PRODUCT_ADDR] = PRODUCT_CODE;
		mem[`VERSION_ADDR] = INIT_VERSION;
		mem[`CFG_IFACE] = `IFACE_RST;
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [1:0] state_r;
	reg [6:0] cnt_r;
	reg [12:0] ptr_r;
	reg [6:0] page_r;
	reg [12:0] src_base_r;
	reg err_r;
	reg done_r;
	reg [7:0] iface_r;
	reg [7:0] slave_byte_r;
	reg [7:0] sam_byte_r;

	reg aw_held_r;
	reg w_held_r;
	reg [11:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;

	// ----------------------------------------------------------------
	// bus handshakes
	// ----------------------------------------------------------------
	assign o_s_axi_awready = i_ce & ~aw_held_r & ~bvalid_r;
	assign o_s_axi_wready = i_ce & ~w_held_r & ~bvalid_r;
	assign o_s_axi_arready = i_ce & ~rvalid_r;
	assign o_s_axi_bvalid = bvalid_r;
	assign o_s_axi_bresp = bresp_r;
	assign o_s_axi_rvalid = rvalid_r;
	assign o_s_axi_rdata = rdata_r;
	assign o_s_axi_rresp = rresp_r;
	assign o_hw_revision = HW_REVISION;
	assign o_boot_done = done_r;

	wire busy = (state_r != ST_IDLE);
	wire wr_go = i_ce & aw_held_r & w_held_r & ~bvalid_r;
	wire rd_go = i_s_axi_arvalid & o_s_axi_arready;
	wire [11:0] wa = {awaddr_r[11:2], 2'b00};
	wire [11:0] ra = {i_s_axi_araddr[11:2], 2'b00};

	wire wr_ptr = wr_go & (wa == `REG_PTR);
	wire wr_data = wr_go & (wa == `REG_DATA);
	wire wr_cmd = wr_go & (wa == `REG_CMD);
	wire wr_stat = wr_go & (wa == `REG_STATUS);
	wire wr_known = wr_ptr | wr_data | wr_cmd | wr_stat;
	wire wr_busy = busy & (wr_ptr | wr_data | wr_cmd);
	wire rd_data = rd_go & (ra == `REG_DATA);

	// ----------------------------------------------------------------
	// section rights
	// ----------------------------------------------------------------
	wire key_hit = (ptr_r >= `KEY_FIRST) && (ptr_r <= `KEY_LAST);
	wire rd_key_bad = rd_data & ~busy & key_hit;
	wire [12:0] prog_addr = {page_r, cnt_r[5:0]};
	wire prog_ok = (prog_addr > `INFO_LAST) &&
		(prog_addr < `PRESET_FIRST);
	wire cmd_prog = wr_cmd & ~busy & wstrb_r[0] &
		wdata_r[`CMD_PROG_BIT];
	wire cmd_reload = wr_cmd & ~busy & wstrb_r[0] &
		wdata_r[`CMD_RELOAD_BIT];
	wire cmd_load = wr_cmd & ~busy & wstrb_r[0] &
		wdata_r[`CMD_LOAD_BIT];
	wire [5:0] load_idx = wdata_r[13:8];
	wire idx_bad = (load_idx >= `PRESET_ENTRIES);
	wire [31:0] load_off = (32'd0 + load_idx) * `PRESET_ENTRY;
	wire [12:0] load_base = `PRESET_FIRST +
		load_off[12:0];

	// ----------------------------------------------------------------
	// write address and data capture
	// ----------------------------------------------------------------
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else if (i_ce) begin
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= i_s_axi_wdata;
				wstrb_r <= i_s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				if (!wr_known || wr_busy) begin
					bresp_r <= `RESP_SLVERR;
				end else begin
					bresp_r <= `RESP_OKAY;
				end
			end else if (bvalid_r && i_s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `RESP_OKAY;
		end else if (i_ce) begin
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rresp_r <= `RESP_OKAY;
				rdata_r <= 32'h00000000;
				case (ra)
				`REG_PTR: begin
					rdata_r <= {19'h00000, ptr_r};
				end
				`REG_DATA: begin
					if (busy || key_hit) begin
						rresp_r <= `RESP_SLVERR;
					end else begin
						rdata_r <= {24'h000000, mem[ptr_r]};
					end
				end
				`REG_CMD: begin
					rdata_r <= 32'h00000000;
				end
				`REG_STATUS: begin
					rdata_r <= {29'h00000000, done_r, err_r, busy};
				end
				`REG_CONFIG: begin
					rdata_r <= {1'b0, o_secure_module_slave_addr, 1'b0,
						o_slave_addr, o_bscan_en, 5'h00,
						o_fast_plus_speed_select, 7'h00, o_host_sel};
				end
				`REG_HWREV: begin
					rdata_r <= {24'h000000, HW_REVISION};
				end
				default: begin
					rresp_r <= `RESP_SLVERR;
				end
				endcase
			end else if (rvalid_r && i_s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// sequencer: boot copy, page program, preset load
	// ----------------------------------------------------------------
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= ST_BOOT;
			cnt_r <= 7'd0;
			ptr_r <= 13'h0000;
			page_r <= 7'd0;
			src_base_r <= `IMG_FIRST;
			err_r <= 1'b0;
			done_r <= 1'b0;
			iface_r <= `IFACE_RST;
			slave_byte_r <= 8'h00;
			sam_byte_r <= 8'h00;
			o_boot_receive_protocol <= 8'h00;
			o_boot_transmit_protocol <= 8'h00;
			o_transmit_check_seed <= 16'h0000;
			o_receive_check_seed <= 16'h0000;
			o_cfg_we <= 1'b0;
			o_cfg_addr <= 8'h00;
			o_cfg_data <= 8'h00;
		end else if (i_ce) begin
			o_cfg_we <= 1'b0;
			if (wr_stat && wstrb_r[0] && wdata_r[`STAT_ERR_BIT]) begin
				err_r <= 1'b0;
			end
			// a new fault in the clearing cycle still sets the flag
			if (rd_key_bad || (wr_go && wr_busy) ||
				(cmd_load && idx_bad)) begin
				err_r <= 1'b1;
			end
			if (wr_ptr && !busy) begin
				if (wstrb_r[0]) begin
					ptr_r[7:0] <= wdata_r[7:0];
				end
				if (wstrb_r[1]) begin
					ptr_r[12:8] <= wdata_r[12:8];
				end
			end
			if ((wr_data && !busy && wstrb_r[0]) ||
				(rd_data && !busy)) begin
				ptr_r <= ptr_r + 13'd1;
			end
			case (state_r)
			ST_IDLE: begin
				cnt_r <= 7'd0;
				if (cmd_prog) begin
					page_r <= ptr_r[12:6];
					state_r <= ST_PROG;
				end else if (cmd_reload) begin
					src_base_r <= `IMG_FIRST;
					done_r <= 1'b0;
					state_r <= ST_BOOT;
				end else if (cmd_load && !idx_bad) begin
					src_base_r <= load_base;
					state_r <= ST_LOAD;
				end
			end
			ST_BOOT: begin
				o_cfg_we <= 1'b1;
				o_cfg_addr <= {1'b0, cnt_r};
				o_cfg_data <= mem[`IMG_FIRST + {6'h00, cnt_r}];
				cnt_r <= cnt_r + 7'd1;
				if (cnt_r == `IMG_BYTES - 1) begin
					iface_r <= mem[`CFG_IFACE];
					slave_byte_r <= mem[`CFG_SLAVE_ADDR];
					sam_byte_r <= mem[`CFG_SAM_ADDR];
					o_boot_receive_protocol <= mem[`CFG_PROT_RX];
					o_boot_transmit_protocol <= mem[`CFG_PROT_TX];
					o_transmit_check_seed <= {mem[`CFG_TX_SEED],
						mem[`CFG_TX_SEED + 13'd1]};
					o_receive_check_seed <= {mem[`CFG_RX_SEED],
						mem[`CFG_RX_SEED + 13'd1]};
					done_r <= 1'b1;
					state_r <= ST_IDLE;
				end
			end
			ST_PROG: begin
				if (!prog_ok) begin
					err_r <= 1'b1;
				end
				cnt_r <= cnt_r + 7'd1;
				if (cnt_r == `PAGE_BYTES - 1) begin
					state_r <= ST_IDLE;
				end
			end
			ST_LOAD: begin
				o_cfg_we <= 1'b1;
				o_cfg_data <= mem[src_base_r + {6'h00, cnt_r}];
				if (cnt_r < `PRESET_TX_BYTES) begin
					o_cfg_addr <= TX_REG_BASE + {1'b0, cnt_r};
				end else begin
					o_cfg_addr <= RX_REG_BASE +
						{1'b0, cnt_r - 7'd16};
				end
				cnt_r <= cnt_r + 7'd1;
				if (cnt_r == `PRESET_ENTRY - 1) begin
					state_r <= ST_IDLE;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// cell and page buffer writes (no reset: non-volatile)
	// ----------------------------------------------------------------
	always @(posedge i_core_clk) begin
		if (i_ce) begin
			if (wr_data && !busy && wstrb_r[0]) begin
				page_buf[ptr_r[5:0]] <= wdata_r[7:0];
			end
			if (state_r == ST_PROG && prog_ok) begin
				mem[prog_addr] <= page_buf[cnt_r[5:0]];
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------------
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_host_sel <= 2'b00;
			o_slave_addr <= 7'h00;
			o_fast_plus_speed_select <= 1'b1;
			o_bscan_en <= 1'b1;
			o_secure_module_slave_addr <= 7'h00;
		end else if (i_ce) begin
			if (iface_r[`IFACE_PINSEL_BIT]) begin
				o_host_sel <= i_host_strap;
			end else begin
				o_host_sel <= iface_r[1:0];
			end
			if (iface_r[`IFACE_ADDRSRC_BIT]) begin
				o_slave_addr <= slave_byte_r[6:0];
			end else begin
				o_slave_addr <= {`PIN_ADDR_PREFIX,
					i_iface_select_pin_c,
					i_iface_select_pin_a};
			end
			o_fast_plus_speed_select <=
				iface_r[`IFACE_SPEED_BIT];
			o_bscan_en <= ~iface_r[`IFACE_BSCAN_BIT];
			o_secure_module_slave_addr <= sam_byte_r[6:0];
		end
	end

endmodule

// file: cfg_bank_model.sv
/* register bank model on the loader's cfg write port.
   assumes one byte per clock and no back-pressure. */
`timescale 1ns/1ps
module cfg_bank_model (
	input wire i_core_clk,
	input wire i_cfg_we,
	input wire [7:0] i_cfg_addr,
	input wire [7:0] i_cfg_data
);
	// --------
	// storage
	// --------
	logic [7:0] regs [0:255];
	always @(posedge i_core_clk) begin
		if (i_cfg_we) begin
			regs[i_cfg_addr] <= i_cfg_data;
		end
	end
endmodule

// file: eeprom_boot_loader_sva.sv
/* port assertions for the loader.
   assumes one clock and i_ce low only while the loader is idle. */
`timescale 1ns/1ps
`include "eeprom_boot_defs.vh"
module eeprom_boot_loader_sva #(
	parameter [7:0] HW_REVISION = 8'h3C
) (
	input wire i_core_clk,
	input wire i_rst_n,
	input wire i_ce,
	input wire o_s_axi_awready,
	input wire o_s_axi_wready,
	input wire [1:0] o_s_axi_bresp,
	input wire o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [11:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	input wire o_s_axi_arready,
	input wire [31:0] o_s_axi_rdata,
	input wire [1:0] o_s_axi_rresp,
	input wire o_s_axi_rvalid,
	input wire i_s_axi_rready,
	input wire [7:0] o_hw_revision,
	input wire o_boot_done,
	input wire o_cfg_we,
	input wire [7:0] o_cfg_addr
);
	// --------
	// helpers
	// --------
	logic [7:0] run_r;
	wire rd_go = i_s_axi_arvalid && o_s_axi_arready;
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_r <= 8'h00;
		end else begin
			run_r <= o_cfg_we ? run_r + 8'h01 : 8'h00;
		end
	end
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// --------
	// checks
	// --------
	a_hwrev_fixed: assert property (o_hw_revision == HW_REVISION)
		else $error("hw revision moved");
	a_burst_len: assert property ($fell(o_cfg_we) |->
		run_r == 8'h80 || run_r == 8'h18) else $error("burst length");
	a_boot_addr: assert property (o_cfg_we && !o_boot_done |->
		o_cfg_addr == run_r) else $error("boot copy address");
	a_b_stands: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
		o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("bresp drop");
	a_r_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
		o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rdata drop");
	a_rd_answer: assert property (rd_go |=> o_s_axi_rvalid)
		else $error("read answer late");
	a_unmapped_err: assert property (rd_go && i_s_axi_araddr == 12'h020 |=>
		o_s_axi_rresp == `RESP_SLVERR && o_s_axi_rdata == 32'h0)
		else $error("unmapped read");
	a_hwrev_read: assert property (rd_go && i_s_axi_araddr == `REG_HWREV |=>
		o_s_axi_rdata[7:0] == HW_REVISION) else $error("hw revision read");
	a_ce_freeze: assert property (!i_ce |->
		!o_s_axi_awready && !o_s_axi_wready && !o_s_axi_arready)
		else $error("ready while frozen");
	c_boot: cover property ($rose(o_boot_done));
	c_preset: cover property ($fell(o_cfg_we) && run_r == 8'h18);
	c_slverr: cover property (o_s_axi_bvalid && o_s_axi_bresp == `RESP_SLVERR);
endmodule

bind eeprom_boot_loader eeprom_boot_loader_sva #(
	.HW_REVISION(HW_REVISION)
) u_sva (
	.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n),
	.i_ce(i_ce),
	.o_s_axi_awready(o_s_axi_awready),
	.o_s_axi_wready(o_s_axi_wready),
	.o_s_axi_bresp(o_s_axi_bresp),
	.o_s_axi_bvalid(o_s_axi_bvalid),
	.i_s_axi_bready(i_s_axi_bready),
	.i_s_axi_araddr(i_s_axi_araddr),
	.i_s_axi_arvalid(i_s_axi_arvalid),
	.o_s_axi_arready(o_s_axi_arready),
	.o_s_axi_rdata(o_s_axi_rdata),
	.o_s_axi_rresp(o_s_axi_rresp),
	.o_s_axi_rvalid(o_s_axi_rvalid),
	.i_s_axi_rready(i_s_axi_rready),
	.o_hw_revision(o_hw_revision),
	.o_boot_done(o_boot_done),
	.o_cfg_we(o_cfg_we),
	.o_cfg_addr(o_cfg_addr)
);

// file: eeprom_map_and_boot_config_tb_top.sv
/* self-checking bench: axi4-lite master tasks, bank model on cfg port.
   assumes the loader's hand-over timing and factory memory image. */
`timescale 1ns/1ps
`include "eeprom_boot_defs.vh"
module eeprom_map_and_boot_config_tb_top;
	localparam [7:0] PCODE = 8'hA5; // arbitrary value
	localparam [7:0] VER = 8'h07; // arbitrary value
	localparam [7:0] HWR = 8'h6B; // arbitrary value
	logic clk = 0, rst_n = 0, ce = 1, awv = 0, wv = 0, bre = 0, arv = 0;
	logic rre = 0, pa = 1, pc = 0;
	logic [1:0] strap = 2'h2, r;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdv;
	wire awr, wr, bv, arr, rv, fp, bs, we, done;
	wire [1:0] br, rr, hs;
	wire [31:0] rdat;
	wire [6:0] sa, secure_key_module;
	wire [7:0] prx, ptx, hw, ca, cd;
	wire [15:0] ts, rs;
	int err_total = 0, num_checks = 0, k;
	eeprom_boot_loader #(.PRODUCT_CODE(PCODE), .INIT_VERSION(VER),
		.HW_REVISION(HWR)) uut (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_ce(ce), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
		.o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
		.i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .o_s_axi_bresp(br),
		.o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .i_s_axi_araddr(ara),
		.i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdat),
		.o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre),
		.i_iface_select_pin_a(pa), .i_iface_select_pin_c(pc),
		.i_host_strap(strap), .o_host_sel(hs), .o_slave_addr(sa),
		.o_fast_plus_speed_select(fp), .o_bscan_en(bs),
		.o_secure_module_slave_addr(secure_key_module), .o_boot_receive_protocol(prx),
		.o_boot_transmit_protocol(ptx), .o_transmit_check_seed(ts),
		.o_receive_check_seed(rs), .o_hw_revision(hw), .o_boot_done(done),
		.o_cfg_we(we), .o_cfg_addr(ca), .o_cfg_data(cd));
	cfg_bank_model bank (.i_core_clk(clk), .i_cfg_we(we), .i_cfg_addr(ca),
		.i_cfg_data(cd));
	// --------
	// tasks
	// --------
	task chk(input [31:0] s, input [31:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task bus_wr(input [11:0] a, input [31:0] d);
		logic ta, tw;
		ta = 0;
		tw = 0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (!ta && awr) begin
				ta = 1;
				awv <= 0;
			end
			if (!tw && wr) begin
				tw = 1;
				wv <= 0;
			end
		end
		// late bready, so the response is seen waiting
		repeat (2) @(posedge clk);
		bre <= 1;
		do @(posedge clk); while (!bv);
		r = br;
		bre <= 0;
	endtask
	task bus_rd(input [11:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1;
		do @(posedge clk); while (!arr);
		arv <= 0;
		@(posedge clk);
		rre <= 1;
		do @(posedge clk); while (!rv);
		rdv = rdat;
		r = rr;
		rre <= 0;
	endtask
	task mem_rd(input [12:0] a);
		bus_wr(`REG_PTR, {19'h0, a});
		bus_rd(`REG_DATA);
	endtask
	task idle;
		bus_rd(`REG_STATUS);
		while (rdv[`STAT_BUSY_BIT]) bus_rd(`REG_STATUS);
	endtask
	function [7:0] fill(input [12:0] b, input int i);
		logic [7:0] f;
		f = i[7:0] ^ 8'hA5;
		if (b == 0) begin
			case (i)
				32: f = 8'h33 + k[7:0];
				33: f = {k[0], 2'b00, k[1], k[0], k == 4 ? 3'b100 : k[2:0]};
				34: f = 8'h44;
				35: f = 8'h05;
				36: f = 8'h06;
				38: f = 8'h12;
				39: f = 8'h34;
				40: f = 8'h56;
				41: f = 8'h78;
				default: f = f;
			endcase
		end
		return f;
	endfunction
	task prog(input [12:0] b);
		bus_wr(`REG_PTR, {19'h0, b});
		for (int i = 0; i < 64; i++) bus_wr(`REG_DATA, {24'h0, fill(b, i)});
		bus_wr(`REG_PTR, {19'h0, b});
		bus_wr(`REG_CMD, 32'h1);
		idle;
	endtask
	// --------
	// sequence
	// --------
	initial forever #25 clk = ~clk;
	initial begin
		#3000000;
		err_total++;
		wrap_up;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		idle;
		chk({done, fp, bs, hs}, 5'h1C);
		chk(sa, {5'h15, pc, pa});
		mem_rd(13'h0001);
		chk(rdv[7:0], PCODE);
		mem_rd(13'h0003);
		chk(rdv[7:0], VER);
		mem_rd(13'h0010);
		chk(r, `RESP_OKAY);
		bus_rd(`REG_HWREV);
		chk(rdv, {24'h0, HWR});
		chk(hw, HWR);
		bus_rd(12'h020);
		chk(r, `RESP_SLVERR);
		for (k = 0; k < 5; k++) begin
			prog(13'h0000);
			chk(rdv[`STAT_ERR_BIT], 1);
			bus_wr(`REG_STATUS, 32'h2);
			bus_wr(`REG_CMD, 32'h2);
			idle;
			chk(rdv[`STAT_ERR_BIT], 0);
			chk({fp, bs}, {k[0], !k[0]});
			chk(sa, k[1] ? 8'h33 + k[7:0] : {5'h15, pc, pa});
			chk(hs, k == 4 ? strap : k[1:0]);
			chk({secure_key_module, prx, ptx}, 23'h440506);
			chk({ts, rs}, 32'h12345678);
			mem_rd(13'h0001);
			chk(rdv[7:0], PCODE);
		end
		bus_rd(`REG_CONFIG);
		chk(rdv, {1'b0, 7'h44, 1'b0, 5'h15, pc, pa, 1'b1, 5'h00, 1'b0,
			7'h00, strap});
		prog(`IMG_FIRST);
		chk(rdv[`STAT_ERR_BIT], 0);
		bus_wr(`REG_CMD, 32'h2);
		idle;
		for (int i = 0; i < 64; i++) begin
			chk({bank.regs[i], bank.regs[64 + i]}, {fill(1, i), 8'h0});
		end
		prog(`KEY_FIRST);
		chk(rdv[`STAT_ERR_BIT], 0);
		mem_rd(`KEY_FIRST);
		chk(r, `RESP_SLVERR);
		chk(rdv, 32'h0);
		bus_wr(`REG_STATUS, 32'h2);
		prog(`PRESET_FIRST);
		chk(rdv[`STAT_ERR_BIT], 1);
		mem_rd(`PRESET_FIRST + 13'd5);
		chk(rdv[7:0], 8'h0);
		bus_wr(`REG_STATUS, 32'h2);
		bus_wr(`REG_CMD, {18'h0, 6'd1, 8'h04});
		idle;
		for (int i = 0; i < 24; i++) chk(bank.regs[8'h28 + i], 8'h0);
		bus_wr(`REG_CMD, {18'h0, 6'd42, 8'h04});
		idle;
		chk(rdv[`STAT_ERR_BIT], 1);
		bus_wr(`REG_CMD, 32'h2);
		bus_wr(`REG_CMD, 32'h2);
		chk(r, `RESP_SLVERR);
		idle;
		ce <= 0;
		repeat (2) @(posedge clk);
		chk({awr, wr, arr}, 3'h0);
		ce <= 1;
		wrap_up;
	end
endmodule
